//--- role_dir_pkg.sv
// Shared constants for the role and direction control of the two-wire bus interface.
// Assumes a core clock of 40 MHz and link-side event logic on its own clock.
package role_dir_pkg;
  typedef enum logic [1:0] {
    SLAVE_RECV,
    SLAVE_XMIT,
    MASTER_RECV,
    MASTER_XMIT
  } role_mode_t;
  localparam logic RST_MASTER = 1'h0;
  localparam logic RST_DIR = 1'h0;
  localparam logic [1:0] MODE_SLAVE_RECV = 2'h0;
  localparam logic [1:0] MODE_SLAVE_XMIT = 2'h1;
  localparam logic [1:0] MODE_MASTER_RECV = 2'h2;
  localparam logic [1:0] MODE_MASTER_XMIT = 2'h3;
  localparam int SYNC_STAGES = 2;
  localparam int EVT_LATENCY_MAX = 4;
endpackage

//--- link_event_cross.sv
// Carries one link-clock event pulse, with a data bit, into the core clock.
// Assumes events are spaced by at least four core clocks.
`timescale 1ns/1ps
module link_event_cross (
  // Link side
  input wire logic i_link_clk,
  input wire logic i_link_pulse,
  input wire logic i_link_data,
  // Core side
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_pulse,
  output logic o_data
);
  logic tog_reg;
  logic tog_next;
  logic dat_reg;
  logic dat_next;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic d_reg;
  logic d_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    tog_next = tog_reg ^ i_link_pulse;
    dat_next = i_link_pulse ? i_link_data : dat_reg;
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_reg <= 1'h0;
      dat_reg <= 1'h0;
    end else begin
      tog_reg <= tog_next;
      dat_reg <= dat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data is stable by the time the toggle is seen, so it is sampled late
  always_comb begin
    d_next = (s2_reg ^ s3_reg) ? dat_reg : d_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
      d_reg <= 1'h0;
    end else begin
      s1_reg <= tog_reg;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      d_reg <= d_next;
    end
  end

  assign o_pulse = s2_reg ^ s3_reg;
  assign o_data = d_next;
endmodule

//--- role_dir_ctrl.sv
// Role and direction control: master select and direction select bits.
// Assumes the software port is on i_clk; bus events come from link-clock logic.
`timescale 1ns/1ps
module role_dir_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Software access
  input wire logic i_rd,
  input wire logic i_wr_master,
  input wire logic i_wr_master_val,
  input wire logic i_wr_dir,
  input wire logic i_wr_dir_val,
  // Link side events
  input wire logic i_link_clk,
  input wire logic i_link_arb_lost,
  input wire logic i_link_addr_match,
  input wire logic i_link_rw_bit,
  input wire logic i_link_ack_end,
  input wire logic i_link_busy,
  // Status
  output logic o_master_select,
  output logic o_direction_select,
  output logic [1:0] o_mode,
  output logic o_dir_pending
);
  logic arb_pulse;
  logic match_pulse;
  logic match_rw;
  logic ack_pulse;
  logic busy_s1_reg;
  logic busy_s2_reg;
  logic master_reg;
  logic master_next;
  logic dir_reg;
  logic dir_next;
  logic mst_lock_reg;
  logic mst_lock_next;
  logic dir_lock_reg;
  logic dir_lock_next;
  logic pend_reg;
  logic pend_next;
  logic pend_val_reg;
  logic pend_val_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  role_dir_pkg::role_mode_t mode_e;

  ////////////////////////////////////////////////////////////////////////
  link_event_cross u_arb (
    .i_link_clk(i_link_clk),
    .i_link_pulse(i_link_arb_lost),
    .i_link_data(1'h0),
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_pulse(arb_pulse),
    .o_data()
  );

  link_event_cross u_match (
    .i_link_clk(i_link_clk),
    .i_link_pulse(i_link_addr_match),
    .i_link_data(i_link_rw_bit),
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_pulse(match_pulse),
    .o_data(match_rw)
  );

  link_event_cross u_ack (
    .i_link_clk(i_link_clk),
    .i_link_pulse(i_link_ack_end),
    .i_link_data(1'h0),
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_pulse(ack_pulse),
    .o_data()
  );

  ////////////////////////////////////////////////////////////////////////
  // Hardware events always win over a software write in the same cycle
  always_comb begin
    master_next = master_reg;
    dir_next = dir_reg;
    mst_lock_next = mst_lock_reg;
    dir_lock_next = dir_lock_reg;
    pend_next = pend_reg;
    pend_val_next = pend_val_reg;
    if (i_rd && !master_reg) begin
      mst_lock_next = 1'h0;
    end
    if (i_rd) begin
      dir_lock_next = 1'h0;
    end
    if (i_wr_master && (!i_wr_master_val || !mst_lock_reg)) begin
      master_next = i_wr_master_val;
    end
    if (i_wr_dir && !dir_lock_reg) begin
      if (busy_s2_reg) begin
        pend_next = 1'h1;
        pend_val_next = i_wr_dir_val;
      end else begin
        dir_next = i_wr_dir_val;
        pend_next = 1'h0;
      end
    end
    if (ack_pulse && pend_reg) begin
      dir_next = pend_val_reg;
      pend_next = 1'h0;
    end
    if (match_pulse && !master_reg) begin
      dir_next = match_rw;
      dir_lock_next = match_rw;
      pend_next = 1'h0;
    end
    if (arb_pulse && master_reg) begin
      master_next = 1'h0;
      dir_next = 1'h0;
      mst_lock_next = 1'h1;
      dir_lock_next = 1'h1;
      pend_next = 1'h0;
    end
    mode_next = {master_next, dir_next};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_reg <= role_dir_pkg::RST_MASTER;
      dir_reg <= role_dir_pkg::RST_DIR;
      mst_lock_reg <= 1'h0;
      dir_lock_reg <= 1'h0;
      pend_reg <= 1'h0;
      pend_val_reg <= 1'h0;
      mode_reg <= role_dir_pkg::MODE_SLAVE_RECV;
      busy_s1_reg <= 1'h0;
      busy_s2_reg <= 1'h0;
    end else begin
      master_reg <= master_next;
      dir_reg <= dir_next;
      mst_lock_reg <= mst_lock_next;
      dir_lock_reg <= dir_lock_next;
      pend_reg <= pend_next;
      pend_val_reg <= pend_val_next;
      mode_reg <= mode_next;
      busy_s1_reg <= i_link_busy;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  assign mode_e = role_dir_pkg::role_mode_t'(mode_reg);
  assign o_master_select = master_reg;
  assign o_direction_select = dir_reg;
  assign o_mode = mode_reg;
  assign o_dir_pending = pend_reg;

  ////////////////////////////////////////////////////////////////////////
  arb_clears_both_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    arb_pulse && master_reg |=> !master_reg && !dir_reg)
    else $error("arbitration loss did not clear both bits");

  arb_slave_recv_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    arb_pulse && master_reg |=> mode_e == role_dir_pkg::SLAVE_RECV)
    else $error("mode not slave receive after arbitration loss");

  mode_decode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_mode == {o_master_select, o_direction_select})
    else $error("mode does not match the two select bits");

  match_sets_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    match_pulse && match_rw && !master_reg && !arb_pulse |=> dir_reg)
    else $error("read address match did not select transmit");

  match_recv_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    match_pulse && !match_rw && !master_reg |=> !dir_reg)
    else $error("write address match did not select receive");

  dir_held_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr_dir && !dir_lock_reg && busy_s2_reg && !match_pulse && !arb_pulse && !ack_pulse
    |=> pend_reg && $stable(dir_reg))
    else $error("direction changed during a transfer");

  pend_applied_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ack_pulse && pend_reg && !match_pulse && !arb_pulse |=> dir_reg == $past(pend_val_reg) && !pend_reg)
    else $error("pending direction not applied at byte end");

  master_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr_master && !i_wr_master_val |=> !master_reg)
    else $error("write of zero did not clear master select");

  master_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mst_lock_reg && !i_rd ##1 i_wr_master && i_wr_master_val && mst_lock_reg |=> !master_reg)
    else $error("master set without a read after arbitration loss");

  dir_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr_dir && !dir_lock_reg && !busy_s2_reg && !match_pulse && !arb_pulse && !ack_pulse
    |=> dir_reg == $past(i_wr_dir_val))
    else $error("idle direction write not applied");
endmodule

//--- link_partner.sv
// Far-side model: other bus parties, seen as link-clock events.
// Assumes the bench calls its tasks; each pulse lasts one link clock.
`timescale 1ns/1ps
module link_partner (
  // Link clock
  input wire logic i_link_clk,
  // Events toward the block
  output logic o_arb_lost,
  output logic o_addr_match,
  output logic o_rw_bit,
  output logic o_ack_end,
  output logic o_busy
);
  ////////////////////////////////////////
  initial begin
    o_arb_lost = 1'h0;
    o_addr_match = 1'h0;
    o_rw_bit = 1'h0;
    o_ack_end = 1'h0;
    o_busy = 1'h0;
  end
  // Kind 0 lost arbitration, 1 address match, 2 acknowledge end
  task automatic send(input logic [1:0] kind, input logic rw);
    @(posedge i_link_clk);
    #2;
    o_arb_lost = (kind == 2'h0);
    o_addr_match = (kind == 2'h1);
    o_ack_end = (kind == 2'h2);
    o_rw_bit = rw;
    @(posedge i_link_clk);
    #2;
    o_arb_lost = 1'h0;
    o_addr_match = 1'h0;
    o_ack_end = 1'h0;
    // Bit is stale here; flip it so nothing leans on it
    o_rw_bit = ~rw;
  endtask
  task automatic set_busy(input logic b);
    @(posedge i_link_clk);
    #2;
    o_busy = b;
  endtask
endmodule

//--- i2c_role_direction_control_test.sv
// Bench for the role and direction control block.
// Assumes the link partner model drives all link-side events.
`timescale 1ns/1ps
module i2c_role_direction_control_test;
  typedef struct packed {logic [1:0] op; logic val; logic [1:0] mode;} row_t;
  logic i_clk, i_link_clk, i_rst_n, i_rd, i_wr_master, i_wr_master_val, i_wr_dir, i_wr_dir_val;
  logic arb_lost, addr_match, rw_bit, ack_end, busy, o_master_select, o_direction_select;
  logic o_dir_pending;
  logic [1:0] o_mode;
  int mismatches = 0;
  int cmp_count = 0;
  row_t rows [6];
  ////////////////////////////////////////
  role_dir_ctrl DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(i_rd),
    .i_wr_master(i_wr_master), .i_wr_master_val(i_wr_master_val), .i_wr_dir(i_wr_dir),
    .i_wr_dir_val(i_wr_dir_val), .i_link_clk(i_link_clk), .i_link_arb_lost(arb_lost),
    .i_link_addr_match(addr_match), .i_link_rw_bit(rw_bit), .i_link_ack_end(ack_end),
    .i_link_busy(busy), .o_master_select(o_master_select),
    .o_direction_select(o_direction_select), .o_mode(o_mode), .o_dir_pending(o_dir_pending));
  link_partner bus (.i_link_clk(i_link_clk), .o_arb_lost(arb_lost),
    .o_addr_match(addr_match), .o_rw_bit(rw_bit), .o_ack_end(ack_end), .o_busy(busy));
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Odd offset keeps the two clocks out of step
  initial begin
    i_link_clk = 1'h0;
    #3.3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Op 0 master write, 1 direction write, 2 read
  task automatic sw(input logic [1:0] op, input logic val);
    @(posedge i_clk);
    #2;
    i_wr_master = (op == 2'h0);
    i_wr_dir = (op == 2'h1);
    i_rd = (op == 2'h2);
    i_wr_master_val = val;
    i_wr_dir_val = val;
    @(posedge i_clk);
    #2;
    i_wr_master = 1'h0;
    i_wr_dir = 1'h0;
    i_rd = 1'h0;
    @(posedge i_clk);
    #2;
  endtask
  task automatic wait_mode(input logic [1:0] exp);
    int n;
    n = 0;
    while (o_mode !== exp && n < 12) begin
      @(posedge i_clk);
      #2;
      n++;
    end
    if (n == 12) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  initial begin
    {i_rd, i_wr_master, i_wr_master_val, i_wr_dir, i_wr_dir_val} = 5'h00;
    i_rst_n = 1'h0;
    rows = '{'{2'h0, 1'h1, 2'h2}, '{2'h1, 1'h1, 2'h3}, '{2'h1, 1'h0, 2'h2},
      '{2'h0, 1'h0, 2'h0}, '{2'h1, 1'h1, 2'h1}, '{2'h1, 1'h0, 2'h0}};
    repeat (5) @(posedge i_clk);
    #2;
    i_rst_n = 1'h1;
    check("reset mode", o_mode, 2'h0);
    check("reset pending", {1'h0, o_dir_pending}, 2'h0);
    foreach (rows[i]) begin
      sw(rows[i].op, rows[i].val);
      check("mode", o_mode, rows[i].mode);
    end
    // Lost arbitration in master transmit, then writes before and after a read
    sw(2'h0, 1'h1);
    sw(2'h1, 1'h1);
    bus.send(2'h0, 1'h0);
    wait_mode(2'h0);
    check("master after loss", {1'h0, o_master_select}, 2'h0);
    check("mode after loss", o_mode, 2'h0);
    sw(2'h0, 1'h1);
    sw(2'h1, 1'h1);
    check("locked writes", o_mode, 2'h0);
    sw(2'h2, 1'h0);
    sw(2'h0, 1'h1);
    sw(2'h1, 1'h1);
    check("writes after read", o_mode, 2'h3);
    // Slave side: address match with both read/write values
    // Transmit first, so a write-bit match has something to undo
    sw(2'h0, 1'h0);
    sw(2'h1, 1'h1);
    check("slave transmit", o_mode, 2'h1);
    bus.send(2'h1, 1'h0);
    wait_mode(2'h0);
    check("match write bit", o_mode, 2'h0);
    bus.send(2'h1, 1'h1);
    wait_mode(2'h1);
    check("match read bit", {1'h0, o_direction_select}, 2'h1);
    sw(2'h1, 1'h0);
    check("clear without read", o_mode, 2'h1);
    sw(2'h2, 1'h0);
    sw(2'h1, 1'h0);
    check("clear after read", o_mode, 2'h0);
    // Direction write in mid-byte waits for the acknowledge end
    bus.set_busy(1'h1);
    repeat (4) @(posedge i_clk);
    sw(2'h1, 1'h1);
    check("held direction", o_mode, 2'h0);
    check("pending", {1'h0, o_dir_pending}, 2'h1);
    bus.send(2'h2, 1'h0);
    wait_mode(2'h1);
    check("pending done", {1'h0, o_dir_pending}, 2'h0);
    // Reset in mid-run drops a held write and the role bits
    sw(2'h0, 1'h1);
    sw(2'h1, 1'h0);
    check("mode before reset", o_mode, 2'h3);
    check("pending before reset", {1'h0, o_dir_pending}, 2'h1);
    i_rst_n = 1'h0;
    repeat (5) @(posedge i_clk);
    #2;
    i_rst_n = 1'h1;
    check("mode after reset", o_mode, 2'h0);
    check("pending after reset", {1'h0, o_dir_pending}, 2'h0);
    sw(2'h0, 1'h1);
    check("master after reset", o_mode, 2'h2);
    bus.set_busy(1'h0);
    tally_and_finish();
  end
endmodule
